// [design/ppic_filter.sv]
// Per-pin digital glitch filter with edge detection
`timescale 1ns/1ps
`default_nettype none
module ppic_filter
    import ppic_pkg::*;
#(
    parameter int N = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         sample_en,
    input  wire logic [N-1:0] level,
    input  wire logic [N-1:0] rise_sel,
    output logic      [N-1:0] edge_o
);
    typedef struct packed {
        logic [N-1:0][2:0] pcnt;
        logic [N-1:0][2:0] acnt;
        logic [N-1:0]      armed;
        logic [N-1:0]      edge_p;
    } ppic_filt_t;

    ppic_filt_t q, d;
    logic [N-1:0] act;

    // Sample counting per pin, counts saturate at four
    always_comb begin
        d = q;
        d.edge_p = '0;
        for (int i = 0; i < N; i++) begin
            act[i] = rise_sel[i] ? level[i] : ~level[i];
            if (sample_en) begin
                if (act[i]) begin
                    d.pcnt[i] = 3'h0;
                    if (q.acnt[i] < FILT_COUNT) d.acnt[i] = q.acnt[i] + 3'h1;
                    if (q.acnt[i] == FILT_COUNT - 3'h1 && q.armed[i]) begin
                        d.edge_p[i] = 1'b1;
                        d.armed[i]  = 1'b0;
                    end
                end else begin
                    d.acnt[i] = 3'h0;
                    if (q.pcnt[i] < FILT_COUNT) d.pcnt[i] = q.pcnt[i] + 3'h1;
                    if (q.pcnt[i] == FILT_COUNT - 3'h1) d.armed[i] = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) q <= '0;
        else q <= d;
    end

    assign edge_o = q.edge_p;

    chk_edge_after_four: assert property (@(posedge clk) disable iff (sys_rst)
        q.edge_p[0] |-> $past(q.acnt[0]) == 3'h3 && $past(act[0]))
        else $error("edge without four active samples");
    chk_edge_single: assert property (@(posedge clk) disable iff (sys_rst)
        q.edge_p[0] |=> !q.edge_p[0])
        else $error("edge pulse longer than one cycle");
    cov_edge: cover property (@(posedge clk) disable iff (sys_rst) q.edge_p[0]);
endmodule // ppic_filter
`default_nettype wire

// [design/ppic_pkg.sv]
// Package with register map and constants of the port pin interrupt block
// Behaviour
// - Polarity picks pull-up or pull-down for inputs
// - Wired-or outputs may keep a pull-up
// - Wired-or bit removes active high drive
// - Mask bit gates each pin interrupt flag
// - Filtered edge of chosen polarity sets flag
// - Per-pin enable and edge polarity
// - All pins share one request line
// - Detection works for inputs and outputs
// - Request when any flag and mask set
// - Pin interrupt wakes from stop and wait
// - Pulses up to 3 clocks ignored, 4 accepted
// - Four passive then four active samples
// - Filters sampled every bus clock when running
// - Stop mode samples on local oscillator ticks
// - Oscillator runs only while an armed pin waits
// - Routing bits move pwm signals to pins
// - Debug pin level captured as mode during reset
// - Data read: pin level for inputs, else data
// - Direction change shows within two clocks
// - Pull enable switches the pull device on for inputs and wired-or outputs
package ppic_pkg;
    localparam int          ADDR_W      = 6;
    localparam logic [5:0]  OFS_DATA    = 6'h00;
    localparam logic [5:0]  OFS_INPUT   = 6'h04;
    localparam logic [5:0]  OFS_DIR     = 6'h08;
    localparam logic [5:0]  OFS_PULL    = 6'h0c;
    localparam logic [5:0]  OFS_POL     = 6'h10;
    localparam logic [5:0]  OFS_WOM     = 6'h14;
    localparam logic [5:0]  OFS_MASK    = 6'h18;
    localparam logic [5:0]  OFS_FLAG    = 6'h1c;
    localparam logic [5:0]  OFS_ROUTE   = 6'h20;
    localparam logic [5:0]  OFS_MODE    = 6'h24;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [2:0]  FILT_COUNT  = 3'h4;
    localparam int          RC_DIV_DEF  = 4;
endpackage

// [design/ppic_top.sv]
// Port pin control with interrupt filters and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module ppic_top
    import ppic_pkg::*;
#(
    parameter int N      = 8,
    parameter int NR     = 2,
    parameter int R_BASE = 2,
    parameter int RC_DIV = RC_DIV_DEF
) (
    input  wire logic                   CLK,
    input  wire logic                   SYS_RST,
    input  wire logic                   S_AXI_AWVALID,
    output logic                        S_AXI_AWREADY,
    input  wire logic [ADDR_W-1:0]      S_AXI_AWADDR,
    input  wire logic                   S_AXI_WVALID,
    output logic                        S_AXI_WREADY,
    input  wire logic [31:0]            S_AXI_WDATA,
    input  wire logic [3:0]             S_AXI_WSTRB,
    output logic                        S_AXI_BVALID,
    input  wire logic                   S_AXI_BREADY,
    output logic [1:0]                  S_AXI_BRESP,
    input  wire logic                   S_AXI_ARVALID,
    output logic                        S_AXI_ARREADY,
    input  wire logic [ADDR_W-1:0]      S_AXI_ARADDR,
    output logic                        S_AXI_RVALID,
    input  wire logic                   S_AXI_RREADY,
    output logic [31:0]                 S_AXI_RDATA,
    output logic [1:0]                  S_AXI_RRESP,
    input  wire logic [N-1:0]           PIN_I,
    output logic      [N-1:0]           PIN_O,
    output logic      [N-1:0]           PIN_OE,
    output logic      [N-1:0]           PULL_UP_EN,
    output logic      [N-1:0]           PULL_DN_EN,
    input  wire logic [NR-1:0]          PWM_IN,
    input  wire logic                   DEBUG_PIN_I,
    input  wire logic                   STOP_MODE,
    input  wire logic                   WAIT_MODE,
    output logic                        MODE_SELECT,
    output logic                        PORT_IRQ,
    output logic                        WAKEUP,
    output logic                        RC_RUN
);
    localparam int RCW = $clog2(RC_DIV + 1);

    if (N < 1 || N > 8 || NR < 1 || R_BASE + NR > N || RC_DIV < 1) begin : g_bad
        $error("ppic_top: unsupported parameter set");
    end

    typedef struct packed {
        logic [N-1:0]      s1;
        logic [N-1:0]      s2;
        logic              d1;
        logic              d2;
        logic              mode;
        logic [N-1:0]      data;
        logic [N-1:0]      dir;
        logic [N-1:0]      pull;
        logic [N-1:0]      pol;
        logic [N-1:0]      wom;
        logic [N-1:0]      mask;
        logic [N-1:0]      flag;
        logic [NR-1:0]     route;
        logic              aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_full;
        logic [31:0]       w_data;
        logic [3:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [RCW-1:0]    rc_cnt;
    } ppic_state_t;

    ppic_state_t  q, d;
    logic [N-1:0] edge_p;
    logic [N-1:0] pad_val;
    logic [N-1:0] pad_drv;
    logic [N-1:0] wr_bits;
    logic         wr_go;
    logic         rd_go;
    logic         rc_need;
    logic         rc_tick;
    logic         samp_en;
    logic [N-1:0] route_mask;
    logic [N-1:0] route_val;

    // Pwm routing onto the alternative pins
    always_comb begin
        route_mask = '0;
        route_val  = '0;
        for (int k = 0; k < NR; k++) begin
            route_mask[R_BASE + k] = q.route[k];
            route_val[R_BASE + k]  = PWM_IN[k];
        end
    end

    // Pad drive, wired-or and pull control
    always_comb begin
        pad_val    = (route_mask & route_val) | (~route_mask & q.data);
        pad_drv    = q.dir | route_mask;
        PIN_O      = pad_val;
        PIN_OE     = pad_drv & ~(q.wom & pad_val);
        PULL_UP_EN = q.pull & ((~pad_drv & ~q.pol) | (pad_drv & q.wom));
        PULL_DN_EN = q.pull & ~pad_drv & q.pol;
    end

    // Stop mode oscillator gating and sample enable
    assign rc_need = |(q.mask & ~q.flag);
    assign RC_RUN  = STOP_MODE & rc_need;
    assign rc_tick = RC_RUN && q.rc_cnt == RCW'(RC_DIV - 1);
    assign samp_en = STOP_MODE ? rc_tick : 1'b1;

    // Filters look at the pin whatever its direction
    ppic_filter #(
        .N (N)
    ) u_filter (
        .clk       (CLK),
        .sys_rst   (SYS_RST),
        .sample_en (samp_en),
        .level     (q.s2),
        .rise_sel  (q.pol),
        .edge_o    (edge_p)
    );

    // Bus handshakes
    assign S_AXI_AWREADY = !q.aw_full && !q.bvalid;
    assign S_AXI_WREADY  = !q.w_full && !q.bvalid;
    assign S_AXI_BVALID  = q.bvalid;
    assign S_AXI_BRESP   = q.bresp;
    assign S_AXI_ARREADY = !q.rvalid;
    assign S_AXI_RVALID  = q.rvalid;
    assign S_AXI_RDATA   = q.rdata;
    assign S_AXI_RRESP   = q.rresp;
    assign wr_go   = q.aw_full && q.w_full && !q.bvalid;
    assign rd_go   = S_AXI_ARVALID && !q.rvalid;
    assign wr_bits = q.w_strb[0] ? q.w_data[N-1:0] : '0;

    // Interrupt request and wakeup
    assign PORT_IRQ    = |(q.flag & q.mask);
    assign WAKEUP      = PORT_IRQ & (STOP_MODE | WAIT_MODE);
    assign MODE_SELECT = q.mode;

    // Next state of the whole block
    always_comb begin
        d = q;
        d.s1 = PIN_I;
        d.s2 = q.s1;
        d.d1 = DEBUG_PIN_I;
        d.d2 = q.d1;
        d.rc_cnt = (!RC_RUN || rc_tick) ? '0 : q.rc_cnt + RCW'(1);
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            d.aw_full = 1'b1;
            d.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            d.w_full = 1'b1;
            d.w_data = S_AXI_WDATA;
            d.w_strb = S_AXI_WSTRB;
        end
        if (S_AXI_BVALID && S_AXI_BREADY) d.bvalid = 1'b0;
        if (wr_go) begin
            d.aw_full = 1'b0;
            d.w_full  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = RESP_OKAY;
            unique case ({q.aw_addr[ADDR_W-1:2], 2'h0})
                OFS_DATA:  if (q.w_strb[0]) d.data = wr_bits;
                OFS_DIR:   if (q.w_strb[0]) d.dir  = wr_bits;
                OFS_PULL:  if (q.w_strb[0]) d.pull = wr_bits;
                OFS_POL:   if (q.w_strb[0]) d.pol  = wr_bits;
                OFS_WOM:   if (q.w_strb[0]) d.wom  = wr_bits;
                OFS_MASK:  if (q.w_strb[0]) d.mask = wr_bits;
                OFS_FLAG:  d.flag = q.flag & ~wr_bits;
                OFS_ROUTE: if (q.w_strb[0]) d.route = q.w_data[NR-1:0];
                OFS_INPUT, OFS_MODE: d.bresp = RESP_OKAY;
                default:   d.bresp = RESP_SLVERR;
            endcase
        end
        // Edge set wins over a clear in the same cycle
        d.flag = d.flag | edge_p;
        if (S_AXI_RVALID && S_AXI_RREADY) d.rvalid = 1'b0;
        if (rd_go) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = '0;
            unique case ({S_AXI_ARADDR[ADDR_W-1:2], 2'h0})
                OFS_DATA:  d.rdata[N-1:0] = (q.dir & q.data) | (~q.dir & q.s2);
                OFS_INPUT: d.rdata[N-1:0] = q.s2;
                OFS_DIR:   d.rdata[N-1:0] = q.dir;
                OFS_PULL:  d.rdata[N-1:0] = q.pull;
                OFS_POL:   d.rdata[N-1:0] = q.pol;
                OFS_WOM:   d.rdata[N-1:0] = q.wom;
                OFS_MASK:  d.rdata[N-1:0] = q.mask;
                OFS_FLAG:  d.rdata[N-1:0] = q.flag;
                OFS_ROUTE: d.rdata[NR-1:0] = q.route;
                OFS_MODE:  d.rdata[0] = q.mode;
                default:   d.rresp = RESP_SLVERR;
            endcase
        end
        if (SYS_RST) begin
            d      = '0;
            d.s1   = PIN_I;
            d.s2   = q.s1;
            d.d1   = DEBUG_PIN_I;
            d.d2   = q.d1;
            d.mode = q.d2;
        end
    end

    // State register
    always_ff @(posedge CLK) begin
        q <= d;
    end

    // Checks on the block behaviour
    logic wr_flag0;
    assign wr_flag0 = wr_go && {q.aw_addr[ADDR_W-1:2], 2'h0} == OFS_FLAG
                      && q.w_strb[0] && q.w_data[0];

    chk_flag_on_edge: assert property (@(posedge CLK) disable iff (SYS_RST)
        edge_p[0] |=> q.flag[0])
        else $error("flag not set after filtered edge");
    chk_flag_w1c: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_flag0 && !edge_p[0] |=> !q.flag[0])
        else $error("write one did not clear flag");
    chk_irq_masked: assert property (@(posedge CLK) disable iff (SYS_RST)
        edge_p[0] && q.mask[0] && !wr_go |=> PORT_IRQ)
        else $error("request missing for masked-in flag");
    chk_irq_blocked: assert property (@(posedge CLK) disable iff (SYS_RST)
        q.mask == '0 |-> !PORT_IRQ)
        else $error("request with all pins masked");
    chk_wor_no_high: assert property (@(posedge CLK) disable iff (SYS_RST)
        q.wom[0] && q.dir[0] && q.data[0] && !route_mask[0] |-> !PIN_OE[0])
        else $error("wired-or pin drives high");
    chk_data_read: assert property (@(posedge CLK) disable iff (SYS_RST)
        rd_go && S_AXI_ARADDR[ADDR_W-1:2] == 4'h0 && q.dir[0]
        |=> S_AXI_RDATA[0] == $past(q.data[0]))
        else $error("data read ignores stored output value");
    chk_rc_gating: assert property (@(posedge CLK) disable iff (SYS_RST)
        STOP_MODE && !rc_need |-> !RC_RUN ##1 (!rc_need || RC_RUN || !STOP_MODE))
        else $error("oscillator running with no armed pin");
    chk_mode_held: assert property (@(posedge CLK) disable iff (SYS_RST)
        $past(!SYS_RST) |-> $stable(q.mode))
        else $error("mode changed outside reset");
    chk_pull_input: assert property (@(posedge CLK) disable iff (SYS_RST)
        q.pull[0] && !pad_drv[0] |-> PULL_UP_EN[0] != PULL_DN_EN[0] && PULL_DN_EN[0] == q.pol[0])
        else $error("pull direction does not follow polarity");
    chk_wake: assert property (@(posedge CLK) disable iff (SYS_RST)
        edge_p[0] && q.mask[0] && STOP_MODE && !wr_go |=> WAKEUP || !STOP_MODE)
        else $error("no wakeup from stop");

    // Pad, read path, interrupt flag and power mode checks
    chk_route_drive: assert property (@(posedge CLK) disable iff (SYS_RST)
        q.route[0] && !q.wom[R_BASE] |-> PIN_OE[R_BASE] && PIN_O[R_BASE] == PWM_IN[0])
        else $error("routed pwm not driven on its pin");
    chk_wor_pullup: assert property (@(posedge CLK) disable iff (SYS_RST)
        q.pull[0] && q.wom[0] && pad_drv[0] |-> PULL_UP_EN[0] && !PULL_DN_EN[0])
        else $error("wired-or pin lost its pull-up");
    chk_out_no_pull: assert property (@(posedge CLK) disable iff (SYS_RST)
        pad_drv[0] && !q.wom[0] |-> !PULL_UP_EN[0] && !PULL_DN_EN[0])
        else $error("pull active on push-pull output");
    chk_pull_up_input: assert property (@(posedge CLK) disable iff (SYS_RST)
        q.pull[0] && !pad_drv[0] && !q.pol[0] |-> PULL_UP_EN[0])
        else $error("pull-up missing on input");
    chk_pull_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        !q.pull[0] |-> !PULL_UP_EN[0] && !PULL_DN_EN[0])
        else $error("pull active without enable");
    chk_wor_low_drive: assert property (@(posedge CLK) disable iff (SYS_RST)
        q.wom[0] && q.dir[0] && !q.data[0] && !route_mask[0] |-> PIN_OE[0] && !PIN_O[0])
        else $error("wired-or pin does not drive low");
    chk_wake_idle: assert property (@(posedge CLK) disable iff (SYS_RST)
        !STOP_MODE && !WAIT_MODE |-> !WAKEUP)
        else $error("wakeup while running");
    chk_wake_wait: assert property (@(posedge CLK) disable iff (SYS_RST)
        PORT_IRQ && WAIT_MODE |-> WAKEUP)
        else $error("no wakeup from wait");
    chk_irq_last_pin: assert property (@(posedge CLK) disable iff (SYS_RST)
        edge_p[N-1] && q.mask[N-1] && !wr_go |=> PORT_IRQ)
        else $error("last pin does not reach the request line");
    chk_input_read: assert property (@(posedge CLK) disable iff (SYS_RST)
        rd_go && {S_AXI_ARADDR[ADDR_W-1:2], 2'h0} == OFS_INPUT
        |=> S_AXI_RDATA[N-1:0] == $past(q.s2))
        else $error("input read not the synced pin level");
    chk_data_in_read: assert property (@(posedge CLK) disable iff (SYS_RST)
        rd_go && S_AXI_ARADDR[ADDR_W-1:2] == 4'h0 && !q.dir[0]
        |=> S_AXI_RDATA[0] == $past(q.s2[0]))
        else $error("data read ignores pin level of input");
    chk_stop_sample: assert property (@(posedge CLK) disable iff (SYS_RST)
        STOP_MODE && !RC_RUN |-> !samp_en)
        else $error("filter sampled with oscillator stopped");
    chk_run_sample: assert property (@(posedge CLK) disable iff (SYS_RST)
        !STOP_MODE |-> samp_en)
        else $error("filter not sampled every clock when running");
    chk_flag_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
        q.flag[0] && !wr_go |=> q.flag[0])
        else $error("flag lost without a write");
    chk_rc_stop_only: assert property (@(posedge CLK) disable iff (SYS_RST)
        !STOP_MODE |-> !RC_RUN)
        else $error("oscillator running outside stop");
    cov_irq: cover property (@(posedge CLK) disable iff (SYS_RST) $rose(PORT_IRQ));
    cov_stop_wake: cover property (@(posedge CLK) disable iff (SYS_RST) STOP_MODE && WAKEUP);
    cov_write_resp: cover property (@(posedge CLK) disable iff (SYS_RST) wr_go ##1 S_AXI_BVALID);
    cov_clear: cover property (@(posedge CLK) disable iff (SYS_RST) wr_flag0);
endmodule // ppic_top
`default_nettype wire

// [tb/ppic_pin_model.sv]
// Pin-side model: external drivers, pull devices and floating lines
`timescale 1ns/1ps
`default_nettype none
module ppic_pin_model #(
    parameter int N = 8
) (
    input  wire logic         clk,
    input  wire logic [N-1:0] pin_o,
    input  wire logic [N-1:0] pin_oe,
    input  wire logic [N-1:0] pull_up_en,
    input  wire logic [N-1:0] pull_dn_en,
    input  wire logic [N-1:0] ext_en,
    input  wire logic [N-1:0] ext_val,
    output logic      [N-1:0] level
);
    logic [N-1:0] last_q;
    // Last level, so an undriven line wanders
    always_ff @(posedge clk) begin
        last_q <= level;
    end
    // Device drive, then outside driver, then pull, else float
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (pin_oe[i]) begin
                level[i] = pin_o[i];
            end else if (ext_en[i]) begin
                level[i] = ext_val[i];
            end else if (pull_up_en[i] | pull_dn_en[i]) begin
                level[i] = pull_up_en[i];
            end else begin
                level[i] = ~last_q[i];
            end
        end
    end
endmodule // ppic_pin_model
`default_nettype wire

// [tb/test_port_pin_interrupt_control.sv]
// Self-checking bench for the port pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_interrupt_control;
    import ppic_pkg::*;
    typedef struct packed {logic [5:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} ppic_row_t;
    localparam ppic_row_t ROWS [7] = '{
        '{OFS_DIR, 32'h5a, 32'h5a, RESP_OKAY}, '{OFS_PULL, 32'h3c, 32'h3c, RESP_OKAY},
        '{OFS_POL, 32'h1ff, 32'hff, RESP_OKAY}, '{OFS_WOM, 32'hf0, 32'hf0, RESP_OKAY},
        '{OFS_MASK, 32'h81, 32'h81, RESP_OKAY}, '{OFS_ROUTE, 32'hff, 32'h3, RESP_OKAY},
        '{6'h28, 32'hff, 32'h0, RESP_SLVERR}};
    logic        clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0;
    logic        rr = 1'h0, dbg = 1'h1, stp = 1'h0, wt = 1'h0;
    logic [3:0]  strb = 4'hf;
    logic [5:0]  awa = 6'h0, ara = 6'h0;
    logic [31:0] wd = 32'h0, rdata, q;
    logic [1:0]  pwm = 2'h0, bresp, rresp, r;
    logic [7:0]  pin_i, pin_o, pin_oe, pu, pd, ext_en = 8'hff, ext_val = 8'h0;
    logic        awr, wr, bv, arr, rv, mode, irq, wake, rc;
    int          miscompares = 0, total_checks = 0;
    // Clock, 5 ns period
    always #2.5 clk = ~clk;
    ppic_top #(.N(8), .NR(2), .R_BASE(2), .RC_DIV(2)) i_ppic_top (
        .CLK(clk), .SYS_RST(rst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(strb), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .PIN_I(pin_i),
        .PIN_O(pin_o), .PIN_OE(pin_oe), .PULL_UP_EN(pu), .PULL_DN_EN(pd), .PWM_IN(pwm),
        .DEBUG_PIN_I(dbg), .STOP_MODE(stp), .WAIT_MODE(wt), .MODE_SELECT(mode),
        .PORT_IRQ(irq), .WAKEUP(wake), .RC_RUN(rc));
    ppic_pin_model #(.N(8)) i_ppic_pin_model (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pull_up_en(pu), .pull_dn_en(pd), .ext_en(ext_en), .ext_val(ext_val), .level(pin_i));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus transfer; holds each channel until its ready, ends off the edge
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'h0;
        @(posedge clk);
        awv <= w;
        wv <= w;
        arv <= !w;
        awa <= a;
        ara <= a;
        wd <= d;
        br <= w;
        rr <= !w;
        while (!tb) begin
            @(negedge clk);
            ta = (awv & awr) | (arv & arr);
            tw = wv & wr;
            tb = w ? (br & bv) : (rr & rv);
            r = w ? bresp : rresp;
            q = rdata;
            @(posedge clk);
            if (ta) awv <= 1'h0;
            if (ta) arv <= 1'h0;
            if (tw) wv <= 1'h0;
        end
        br <= 1'h0;
        rr <= 1'h0;
        @(negedge clk);
    endtask
    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk("rdata", q, e);
    endtask
    // Pulse of len clocks on pin 0 against polarity pol and mask m
    task automatic pulse(input logic pol, input int len, input logic m, input logic ef);
        wreg(OFS_POL, {31'h0, pol});
        wreg(OFS_MASK, {31'h0, m});
        @(posedge clk);
        ext_val[0] <= !pol;
        repeat (10) @(posedge clk);
        wreg(OFS_FLAG, 32'hff);
        @(posedge clk);
        ext_val[0] <= pol;
        repeat (len) @(posedge clk);
        ext_val[0] <= !pol;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk("irq", irq, ef & m);
        chk("wake", wake, ef & m & wt);
        wreg(OFS_FLAG, 32'h0);
        rchk(OFS_FLAG, {31'h0, ef});
        wreg(OFS_FLAG, 32'hff);
        rchk(OFS_FLAG, 32'h0);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run;
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        dbg <= 1'h0;
        @(negedge clk);
        chk("mode", mode, 1'h1);
        chk("oe", pin_oe, 8'h0);
        rchk(OFS_MODE, 32'h1);
        foreach (ROWS[i]) begin
            bus(1'h1, ROWS[i].a, ROWS[i].d);
            chk("bresp", r, ROWS[i].r);
            bus(1'h0, ROWS[i].a, 32'h0);
            chk("rdata", q, ROWS[i].e);
            chk("rresp", r, ROWS[i].r);
        end
        for (int i = 0; i < 9; i++) wreg(6'(4 * i), 32'h0);
        // Pull and wired-or drive on pin 0
        @(posedge clk);
        ext_en[0] <= 1'h0;
        wreg(OFS_PULL, 32'h1);
        chk("pull", {pu[0], pd[0]}, 2'h2);
        wreg(OFS_POL, 32'h1);
        chk("pull", {pu[0], pd[0]}, 2'h1);
        wreg(OFS_DATA, 32'h1);
        wreg(OFS_DIR, 32'h1);
        chk("pull", {pu[0], pd[0]}, 2'h0);
        chk("drive", {pin_oe[0], pin_o[0]}, 2'h3);
        wreg(OFS_WOM, 32'h1);
        chk("pull", {pu[0], pd[0]}, 2'h2);
        chk("oe", pin_oe[0], 1'h0);
        wreg(OFS_DATA, 32'h0);
        chk("drive", {pin_oe[0], pin_o[0]}, 2'h2);
        wreg(OFS_MASK, 32'h1);
        repeat (10) @(posedge clk);
        wreg(OFS_FLAG, 32'hff);
        wreg(OFS_DATA, 32'h1);
        repeat (10) @(posedge clk);
        rchk(OFS_FLAG, 32'h1);
        // Writes without byte lane 0 leave registers alone
        @(posedge clk);
        strb <= 4'he;
        wreg(OFS_FLAG, 32'hff);
        wreg(OFS_DIR, 32'h0);
        rchk(OFS_FLAG, 32'h1);
        rchk(OFS_DIR, 32'h1);
        @(posedge clk);
        strb <= 4'hf;
        for (int i = 0; i < 9; i++) wreg(6'(4 * i), 32'h0);
        wreg(OFS_FLAG, 32'hff);
        // Data and input reads against direction
        @(posedge clk);
        ext_en <= 8'hff;
        ext_val <= 8'ha5;
        repeat (3) @(posedge clk);
        rchk(OFS_DATA, 32'ha5);
        rchk(OFS_INPUT, 32'ha5);
        wreg(OFS_DATA, 32'h0f);
        wreg(OFS_DIR, 32'hf0);
        repeat (2) @(posedge clk);
        rchk(OFS_DATA, 32'h05);
        rchk(OFS_INPUT, 32'h05);
        // Filter lengths, polarities, masking, wait-mode wakeup
        pulse(1'h1, 3, 1'h1, 1'h0);
        @(posedge clk);
        wt <= 1'h1;
        pulse(1'h1, 4, 1'h1, 1'h1);
        @(posedge clk);
        wt <= 1'h0;
        pulse(1'h0, 3, 1'h1, 1'h0);
        pulse(1'h0, 4, 1'h1, 1'h1);
        pulse(1'h1, 4, 1'h0, 1'h1);
        // Stop mode: local oscillator and wakeup
        wreg(OFS_MASK, 32'h1);
        @(posedge clk);
        stp <= 1'h1;
        @(negedge clk);
        chk("rc", rc, 1'h1);
        @(posedge clk);
        ext_val[0] <= 1'h1;
        repeat (7) @(posedge clk);
        @(negedge clk);
        chk("rc", rc, 1'h1);
        repeat (33) @(posedge clk);
        @(negedge clk);
        chk("rc", rc, 1'h0);
        chk("wake", wake, 1'h1);
        @(posedge clk);
        stp <= 1'h0;
        // Pwm routing onto pins 2 and 3
        for (int k = 0; k < 2; k++) begin
            wreg(OFS_ROUTE, 32'h1 << k);
            @(posedge clk);
            pwm <= 2'h3;
            @(negedge clk);
            chk("route", {pin_oe[2 + k], pin_o[2 + k]}, 2'h3);
            @(posedge clk);
            pwm <= 2'h0;
            @(negedge clk);
            chk("route", {pin_oe[2 + k], pin_o[2 + k]}, 2'h2);
        end
        // Second reset captures the low debug pin level
        @(posedge clk);
        rst <= 1'h1;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        chk("mode", mode, 1'h0);
        chk("oe", pin_oe, 8'h0);
        rchk(OFS_ROUTE, 32'h0);
        complete_run;
    end
endmodule // test_port_pin_interrupt_control
`default_nettype wire
